// >>> hdl/osc_ctrl.sv
// Oscillator control, clock switch tracking and status with Avalon-MM register access
// Behaviour
// - switch_complete high when current equals requested
// - new_source_ready only during switch with ready
// - without hold, switch one instruction after ready
// - six-bit signed trim, zero is centre
// - four-bit frequency code, 1 to 64 MHz
// - eight ready flags, running and ready
// - multiplier ready needs enable, input, lock
// - force-on bit or peripheral request runs source, bit 1 by peripheral request only; multiplier runs from its enable bit only
// - high-frequency oscillator runs at last selected non-reserved frequency
// - secondary oscillator power mode from select bit
// - external oscillator mode from configuration
// - peripherals get external times four when enabled
// - multiplier enable never touches system clock
// - monitor register bits 5..0 RW, 7..6 zero
// - fault inject blocks monitored clock input
// - failure flags stick until software clears
// - switch hold delays switch when source ready
// - auto tuning overwrites trim each tuning cycle
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/10ps
module osc_ctrl (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Avalon-MM slave
  input wire osc_ctrl_pkg::avmm_req_t bus_in,
  output osc_ctrl_pkg::avmm_rsp_t bus_out,
  // Oscillator analog side
  input wire osc_ctrl_pkg::osc_vec_t osc_ready_in,
  input wire logic mult_lock_in,
  input wire logic [7:0] periph_req_in,
  input wire logic [1:0] ext_osc_config_in,
  output osc_ctrl_pkg::osc_vec_t osc_run_out,
  output logic [3:0] hf_freq_code_out,
  output logic [5:0] freq_trim_out,
  output logic secondary_power_select_out,
  output logic [1:0] ext_osc_mode_out,
  output logic periph_ext_x4_out,
  // System clock selection
  output logic [6:0] sys_source_out,
  // Automatic tuning
  input wire logic tune_tick_in,
  input wire logic [5:0] tune_value_in,
  // Fail-safe monitor
  input wire logic [2:0] mon_fail_in,
  output logic [2:0] mon_block_out
);
  logic [7:0] switch_reg;
  logic [7:0] enable_reg;
  logic [5:0] trim_reg;
  logic [3:0] freq_reg;
  logic [3:0] run_freq_reg;
  logic [1:0] tune_reg;
  logic [6:0] request_reg;
  logic [6:0] current_reg;
  logic [1:0] delay_reg;
  logic [31:0] rdata_reg;
  logic rvalid_reg;
  osc_ctrl_pkg::switch_state_t state_reg;
  logic [7:0] ready_sync;
  logic [7:0] ready_status;
  logic [7:0] running;
  logic [7:0] mon_value;
  logic [7:0] addr;
  logic wr;
  logic src_ready;
  logic in_switch;
  logic new_ready;
  logic [7:0] wd;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode: byte address is four times the register index
  assign addr = bus_in.address[9:2];
  assign wr = bus_in.write;
  assign wd = bus_in.writedata[7:0];
  // Writes take effect at once; reads wait one cycle for registered data
  assign bus_out.waitrequest = bus_in.read && !rvalid_reg;
  assign bus_out.readdata = rdata_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= bus_in.read && !rvalid_reg;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus_in.read) begin
      case (addr)
        osc_ctrl_pkg::REQUEST_IDX: rdata_reg <= {25'h0, request_reg};
        osc_ctrl_pkg::CURRENT_IDX: rdata_reg <= {25'h0, current_reg};
        osc_ctrl_pkg::SWITCH_IDX: rdata_reg <= {24'h0, switch_reg[7:6], 1'b0,
          (current_reg == request_reg), new_ready, 3'h0};
        osc_ctrl_pkg::READY_IDX: rdata_reg <= {24'h0, ready_status};
        osc_ctrl_pkg::ENABLE_IDX: rdata_reg <= {24'h0, enable_reg};
        osc_ctrl_pkg::TRIM_IDX: rdata_reg <= {26'h0, trim_reg};
        osc_ctrl_pkg::FREQ_IDX: rdata_reg <= {28'h0, freq_reg};
        osc_ctrl_pkg::TUNE_IDX: rdata_reg <= {24'h0, tune_reg, 6'h0};
        osc_ctrl_pkg::MONITOR_IDX: rdata_reg <= {24'h0, mon_value};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      enable_reg <= osc_ctrl_pkg::ENABLE_RST;
    end else if (wr && addr == osc_ctrl_pkg::ENABLE_IDX) begin
      enable_reg <= wd & osc_ctrl_pkg::ENABLE_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      freq_reg <= osc_ctrl_pkg::FREQ_RST;
      run_freq_reg <= osc_ctrl_pkg::FREQ_RST;
    end else begin
      if (wr && addr == osc_ctrl_pkg::FREQ_IDX) begin
        freq_reg <= wd[3:0];
      end
      if (freq_reg <= osc_ctrl_pkg::FREQ_MAX) begin
        run_freq_reg <= freq_reg;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      tune_reg <= 2'b00;
    end else if (wr && addr == osc_ctrl_pkg::TUNE_IDX) begin
      tune_reg <= wd[7:6];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      trim_reg <= osc_ctrl_pkg::TRIM_RST;
    end else if (tune_reg[1] && !tune_reg[0] && tune_tick_in) begin
      trim_reg <= tune_value_in;
    end else if (wr && addr == osc_ctrl_pkg::TRIM_IDX) begin
      trim_reg <= wd[5:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock switch: request, hold and completion
  assign src_ready = ready_sync[7 - request_reg[6:4]];
  assign in_switch = current_reg != request_reg;
  assign new_ready = (state_reg == osc_ctrl_pkg::SW_READY) && in_switch;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      request_reg <= osc_ctrl_pkg::SOURCE_RST;
    end else if (wr && addr == osc_ctrl_pkg::REQUEST_IDX) begin
      request_reg <= wd[6:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      switch_reg <= osc_ctrl_pkg::SWITCH_RST;
    end else if (wr && addr == osc_ctrl_pkg::SWITCH_IDX) begin
      switch_reg <= {wd[7:6], 6'h00};
    end else if (state_reg == osc_ctrl_pkg::SW_APPLY) begin
      switch_reg[osc_ctrl_pkg::HOLD_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_reg <= osc_ctrl_pkg::SW_IDLE;
      delay_reg <= 2'b00;
      current_reg <= osc_ctrl_pkg::SOURCE_RST;
    end else begin
      case (state_reg)
        osc_ctrl_pkg::SW_IDLE: begin
          if (in_switch) begin
            state_reg <= osc_ctrl_pkg::SW_WAIT;
          end
        end
        osc_ctrl_pkg::SW_WAIT: begin
          if (!in_switch) begin
            state_reg <= osc_ctrl_pkg::SW_IDLE;
          end else if (src_ready) begin
            state_reg <= osc_ctrl_pkg::SW_READY;
            delay_reg <= 2'(osc_ctrl_pkg::INSTR_CYC - 1);
          end
        end
        osc_ctrl_pkg::SW_READY: begin
          if (!in_switch) begin
            state_reg <= osc_ctrl_pkg::SW_IDLE;
          end else if (!src_ready) begin
            state_reg <= osc_ctrl_pkg::SW_WAIT;
          end else if (switch_reg[osc_ctrl_pkg::HOLD_BIT]) begin
            state_reg <= osc_ctrl_pkg::SW_READY;
          end else if (delay_reg != 2'b00) begin
            delay_reg <= delay_reg - 2'b01;
          end else begin
            state_reg <= osc_ctrl_pkg::SW_APPLY;
          end
        end
        osc_ctrl_pkg::SW_APPLY: begin
          current_reg <= request_reg;
          state_reg <= osc_ctrl_pkg::SW_IDLE;
        end
        default: state_reg <= osc_ctrl_pkg::SW_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator enables and status
  ready_sync u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .raw_in(osc_ready_in),
    .sync_out(ready_sync)
  );

  always_comb begin
    running = enable_reg | periph_req_in;
    running[0] = enable_reg[osc_ctrl_pkg::PERIPH_MULT_BIT];
  end

  assign ready_status[7:1] = ready_sync[7:1] & running[7:1];
  assign ready_status[0] = ready_sync[0] && running[0] && ready_sync[7]
    && running[7] && mult_lock_in;

  assign osc_run_out = running;
  assign hf_freq_code_out = run_freq_reg;
  assign freq_trim_out = trim_reg;
  assign secondary_power_select_out = switch_reg[osc_ctrl_pkg::PWR_BIT];
  assign ext_osc_mode_out = ext_osc_config_in;
  assign periph_ext_x4_out = enable_reg[osc_ctrl_pkg::PERIPH_MULT_BIT];
  assign sys_source_out = current_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Fail-safe monitor
  fail_monitor u_mon (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .wr_in(wr && addr == osc_ctrl_pkg::MONITOR_IDX),
    .wdata_in(wd & osc_ctrl_pkg::MONITOR_MASK),
    .fail_in(mon_fail_in),
    .value_out(mon_value),
    .block_out(mon_block_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  a_switch_done: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state_reg == osc_ctrl_pkg::SW_APPLY |=> current_reg == $past(request_reg))
    else $error("switch did not complete");
  a_newrdy_valid: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state_reg == osc_ctrl_pkg::SW_READY |-> in_switch)
    else $error("new source ready outside switch");
  a_nohold_fast: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state_reg == osc_ctrl_pkg::SW_READY && !switch_reg[7] && src_ready && !wr
    |-> ##[1:5] state_reg != osc_ctrl_pkg::SW_READY)
    else $error("switch not applied after ready");
  a_hold_stays: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state_reg == osc_ctrl_pkg::SW_READY && switch_reg[7] && src_ready && !wr
    |=> state_reg == osc_ctrl_pkg::SW_READY)
    else $error("switch proceeded under hold");
  a_pll_ready: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !mult_lock_in || !enable_reg[0] |-> !ready_status[0])
    else $error("multiplier ready without lock or enable");
  a_ready_gated: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (ready_status[7:1] & ~running[7:1]) == 7'h00)
    else $error("ready flag set for stopped source");
  a_reserved_freq: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    freq_reg > osc_ctrl_pkg::FREQ_MAX |=> hf_freq_code_out == $past(hf_freq_code_out))
    else $error("reserved code changed frequency");
  a_tune_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    tune_reg == 2'b10 && tune_tick_in |=> trim_reg == $past(tune_value_in))
    else $error("tuning did not overwrite trim");
  a_force_on: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (enable_reg[7:1] & ~osc_run_out[7:1]) == 7'h00)
    else $error("forced source not running");
  a_sys_stable: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state_reg != osc_ctrl_pkg::SW_APPLY |=> $stable(sys_source_out))
    else $error("system source changed outside switch");
  a_sync_delay: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (ready_status[7:1] & ~$past(osc_ready_in[7:1], 2)) == 7'h00)
    else $error("ready shown before synchronisation");
  a_trim_kept: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    tune_reg != 2'b10 && !wr |=> trim_reg == $past(trim_reg))
    else $error("trim changed without tuning or write");
  a_hold_cleared: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state_reg == osc_ctrl_pkg::SW_APPLY && !wr |=> !switch_reg[osc_ctrl_pkg::HOLD_BIT])
    else $error("hold not released after switch");
endmodule

// >>> hdl/osc_ctrl_pkg.sv
// Package: register map, field layout, reset values and types of the oscillator block
package osc_ctrl_pkg;
  // Register word indices (printed offsets are word indices, not all multiples of four)
  localparam logic [7:0] SWITCH_IDX = 8'h7C;
  localparam logic [7:0] READY_IDX = 8'h7D;
  localparam logic [7:0] ENABLE_IDX = 8'h7E;
  localparam logic [7:0] TRIM_IDX = 8'h7F;
  localparam logic [7:0] FREQ_IDX = 8'h80;
  localparam logic [7:0] TUNE_IDX = 8'h81;
  localparam logic [7:0] MONITOR_IDX = 8'h82;
  localparam logic [7:0] REQUEST_IDX = 8'h7A;
  localparam logic [7:0] CURRENT_IDX = 8'h7B;
  localparam int ADDR_W = 10;
  // Switch control fields
  localparam int HOLD_BIT = 7;
  localparam int PWR_BIT = 6;
  localparam int DONE_BIT = 4;
  localparam int NEW_RDY_BIT = 3;
  // Enable register fields
  localparam int PERIPH_MULT_BIT = 0;
  localparam logic [7:0] ENABLE_MASK = 8'hFD;
  // Tuning control fields
  localparam int TUNE_EN_BIT = 7;
  localparam int TUNE_HOLD_BIT = 6;
  // Monitor fields
  localparam logic [7:0] MONITOR_MASK = 8'h3F;
  localparam logic [7:0] INJECT_MASK = 8'h2A;
  // Reset values and frequency code limit
  localparam logic [7:0] SWITCH_RST = 8'h40;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [5:0] TRIM_RST = 6'h00;
  localparam logic [3:0] FREQ_RST = 4'h0;
  localparam logic [3:0] FREQ_MAX = 4'h8;
  localparam logic [6:0] SOURCE_RST = 7'h00;
  localparam logic [7:0] MONITOR_RST = 8'h00;
  // Instruction cycle: four system clocks
  localparam int INSTR_NS = 32;
  localparam int CLK_NS = 8;
  localparam int INSTR_CYC = (INSTR_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } avmm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avmm_rsp_t;

  // Oscillator per-source vector, bit 7 external down to bit 0 multiplier
  typedef struct packed {
    logic ext;
    logic hf;
    logic mid;
    logic low;
    logic sec;
    logic conv;
    logic slow;
    logic mult;
  } osc_vec_t;

  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_WAIT = 2'b01,
    SW_READY = 2'b10,
    SW_APPLY = 2'b11
  } switch_state_t;
endpackage

// >>> hdl/ready_sync.sv
// Two-flop synchroniser for the eight oscillator ready indications
`timescale 1ns/10ps
module ready_sync (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Raw and synchronised ready levels
  input wire logic [7:0] raw_in,
  output logic [7:0] sync_out
);
  logic [7:0] meta_reg;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
          meta_reg[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_reg[i] <= raw_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule

// >>> hdl/fail_monitor.sv
// Fail-safe monitor control and status: fault injection and sticky failure flags
`timescale 1ns/10ps
module fail_monitor (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Software access
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  // Failure detections: bit 2 secondary, bit 1 primary, bit 0 system clock
  input wire logic [2:0] fail_in,
  output logic [7:0] value_out,
  output logic [2:0] block_out
);
  logic [7:0] mon_reg;

  // Fault inject bits 5,3,1; flags 4,2,0
  assign block_out = {mon_reg[5], mon_reg[3], mon_reg[1]};
  assign value_out = mon_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      mon_reg <= osc_ctrl_pkg::MONITOR_RST;
    end else begin
      for (int k = 0; k < 3; k++) begin
        // Inject bit written plainly; flag set wins over a clearing write
        if (wr_in) begin
          mon_reg[2*k+1] <= wdata_in[2*k+1];
        end
        if (fail_in[k] || mon_reg[2*k+1]) begin
          mon_reg[2*k] <= 1'b1;
        end else if (wr_in) begin
          mon_reg[2*k] <= wdata_in[2*k];
        end
      end
      mon_reg[7:6] <= 2'b00;
    end
  end

  a_flag_sticky: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(mon_reg[0]) && !wr_in |=> mon_reg[0])
    else $error("fail flag dropped without write");
  a_inject_sets: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    mon_reg[1] |=> mon_reg[0])
    else $error("fault injection did not raise flag");
  a_top_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ##1 value_out[7:6] == 2'b00)
    else $error("unimplemented monitor bits nonzero");
endmodule

// >>> dv/tb.sv
// Self-checking bench for the oscillator control block
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (got), (exp)); end end
module tb;
  logic clk_in;
  logic rst_b_in;
  osc_ctrl_pkg::avmm_req_t bus_req;
  osc_ctrl_pkg::avmm_rsp_t bus_rsp;
  osc_ctrl_pkg::osc_vec_t rdy;
  osc_ctrl_pkg::osc_vec_t run;
  logic lock;
  logic [7:0] preq;
  logic [1:0] ext_cfg;
  logic [1:0] ext_mode;
  logic [3:0] hf_code;
  logic [5:0] trim;
  logic sec_pwr;
  logic x4;
  logic [6:0] sys_src;
  logic tick;
  logic [5:0] tune_val;
  logic [2:0] fail;
  logic [2:0] block;
  logic [31:0] rd;
  int miscompares;
  int checked;

  osc_ctrl dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .bus_in(bus_req), .bus_out(bus_rsp),
    .osc_ready_in(rdy), .mult_lock_in(lock), .periph_req_in(preq),
    .ext_osc_config_in(ext_cfg), .osc_run_out(run), .hf_freq_code_out(hf_code),
    .freq_trim_out(trim), .secondary_power_select_out(sec_pwr),
    .ext_osc_mode_out(ext_mode), .periph_ext_x4_out(x4), .sys_source_out(sys_src),
    .tune_tick_in(tick), .tune_value_in(tune_val), .mon_fail_in(fail),
    .mon_block_out(block)
  );

  always #4 clk_in = ~clk_in;

  ////////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("Checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One Avalon-MM transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk_in);
    bus_req <= '{address: {idx, 2'b00}, read: !wr, write: wr, writedata: {24'h0, wd}};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (bus_rsp.waitrequest !== 1'b0 && n < 20);
    if (bus_rsp.waitrequest !== 1'b0) begin
      miscompares++;
      $display("[FAIL] %0t bus timeout", $time);
      summarize();
    end else begin
      rd = bus_rsp.readdata;
      bus_req <= '{address: {idx, 2'b00}, read: 1'b0, write: 1'b0, writedata: 32'h0};
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    `CHK(rd, {24'h0, exp})
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  // Bounded wait for the system source; the bound is the allowed switch time
  task automatic wait_src(input logic [6:0] v, input int lim);
    int n;
    n = 0;
    while (sys_src !== v && n < lim) begin
      @(negedge clk_in);
      n++;
    end
    if (sys_src !== v) begin
      miscompares++;
      $display("[FAIL] %0t switch timeout", $time);
      summarize();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rdchk(osc_ctrl_pkg::READY_IDX, 8'h00);
    rdchk(osc_ctrl_pkg::ENABLE_IDX, 8'h00);
    rdchk(osc_ctrl_pkg::TRIM_IDX, 8'h00);
    rdchk(osc_ctrl_pkg::FREQ_IDX, 8'h00);
    rdchk(osc_ctrl_pkg::MONITOR_IDX, 8'h00);
    rdchk(osc_ctrl_pkg::SWITCH_IDX, 8'h50);
    wr(8'h90, 8'hFF);
    rdchk(8'h90, 8'h00);
    idle(1);
    `CHK(run, 8'h00)
    `CHK(sec_pwr, 1'b1)
    `CHK(x4, 1'b0)
    $display("t_reset done");
  endtask

  task t_enable;
    wr(osc_ctrl_pkg::ENABLE_IDX, 8'hFF);
    rdchk(osc_ctrl_pkg::ENABLE_IDX, 8'hFD);
    rdy <= 8'hFF;
    lock <= 1'b1;
    idle(4);
    `CHK(run, 8'hFD)
    `CHK(x4, 1'b1)
    `CHK(sys_src, 7'h00)
    rdchk(osc_ctrl_pkg::READY_IDX, 8'hFD);
    lock <= 1'b0;
    idle(4);
    rdchk(osc_ctrl_pkg::READY_IDX, 8'hFC);
    lock <= 1'b1;
    rdy.ext <= 1'b0;
    idle(4);
    rdchk(osc_ctrl_pkg::READY_IDX, 8'h7C);
    wr(osc_ctrl_pkg::ENABLE_IDX, 8'h00);
    preq <= 8'h02;
    ext_cfg <= 2'b10;
    idle(4);
    `CHK(run, 8'h02)
    `CHK(ext_mode, 2'b10)
    rdchk(osc_ctrl_pkg::READY_IDX, 8'h02);
    preq <= 8'h00;
    rdy <= 8'h00;
    $display("t_enable done");
  endtask

  task t_freq;
    for (logic [7:0] c = 8'h00; c <= 8'h08; c++) begin
      wr(osc_ctrl_pkg::FREQ_IDX, c);
      rdchk(osc_ctrl_pkg::FREQ_IDX, c);
      idle(1);
      `CHK(hf_code, c[3:0])
    end
    wr(osc_ctrl_pkg::FREQ_IDX, 8'h0A);
    idle(2);
    `CHK(hf_code, 4'h8)
    $display("t_freq done");
  endtask

  task t_trim;
    wr(osc_ctrl_pkg::TRIM_IDX, 8'h1F);
    idle(1);
    `CHK(trim, 6'h1F)
    wr(osc_ctrl_pkg::TRIM_IDX, 8'hE0);
    rdchk(osc_ctrl_pkg::TRIM_IDX, 8'h20);
    wr(osc_ctrl_pkg::TUNE_IDX, 8'h80);
    tune_val <= 6'h15;
    tick <= 1'b1;
    @(posedge clk_in);
    tick <= 1'b0;
    rdchk(osc_ctrl_pkg::TRIM_IDX, 8'h15);
    wr(osc_ctrl_pkg::TUNE_IDX, 8'hC0);
    tune_val <= 6'h0A;
    tick <= 1'b1;
    @(posedge clk_in);
    tick <= 1'b0;
    idle(1);
    `CHK(trim, 6'h15)
    wr(osc_ctrl_pkg::TUNE_IDX, 8'h00);
    wr(osc_ctrl_pkg::TRIM_IDX, 8'h00);
    $display("t_trim done");
  endtask

  task t_mon;
    wr(osc_ctrl_pkg::MONITOR_IDX, 8'hFF);
    rdchk(osc_ctrl_pkg::MONITOR_IDX, 8'h3F);
    idle(1);
    `CHK(block, 3'b111)
    wr(osc_ctrl_pkg::MONITOR_IDX, 8'h15);
    rdchk(osc_ctrl_pkg::MONITOR_IDX, 8'h15);
    wr(osc_ctrl_pkg::MONITOR_IDX, 8'h00);
    rdchk(osc_ctrl_pkg::MONITOR_IDX, 8'h00);
    fail <= 3'b010;
    @(posedge clk_in);
    fail <= 3'b000;
    idle(2);
    rdchk(osc_ctrl_pkg::MONITOR_IDX, 8'h04);
    wr(osc_ctrl_pkg::MONITOR_IDX, 8'h00);
    rdchk(osc_ctrl_pkg::MONITOR_IDX, 8'h00);
    wr(osc_ctrl_pkg::MONITOR_IDX, 8'h08);
    idle(1);
    `CHK(block, 3'b010)
    rdchk(osc_ctrl_pkg::MONITOR_IDX, 8'h0C);
    wr(osc_ctrl_pkg::MONITOR_IDX, 8'h00);
    $display("t_mon done");
  endtask

  task t_switch;
    wr(osc_ctrl_pkg::SWITCH_IDX, 8'h00);
    idle(1);
    `CHK(sec_pwr, 1'b0)
    wr(osc_ctrl_pkg::SWITCH_IDX, 8'h40);
    wr(osc_ctrl_pkg::ENABLE_IDX, 8'h28);
    wr(osc_ctrl_pkg::REQUEST_IDX, 8'h23);
    rdchk(osc_ctrl_pkg::SWITCH_IDX, 8'h40);
    rdchk(osc_ctrl_pkg::CURRENT_IDX, 8'h00);
    rdy <= 8'h20;
    wait_src(7'h23, 2 + 2 * osc_ctrl_pkg::INSTR_CYC + 1);
    `CHK(sys_src, 7'h23)
    rdchk(osc_ctrl_pkg::SWITCH_IDX, 8'h50);
    rdchk(osc_ctrl_pkg::CURRENT_IDX, 8'h23);
    wr(osc_ctrl_pkg::SWITCH_IDX, 8'hC0);
    wr(osc_ctrl_pkg::REQUEST_IDX, 8'h45);
    rdy <= 8'h28;
    idle(12);
    `CHK(sys_src, 7'h23)
    rdchk(osc_ctrl_pkg::SWITCH_IDX, 8'hC8);
    wr(osc_ctrl_pkg::SWITCH_IDX, 8'h40);
    wait_src(7'h45, osc_ctrl_pkg::INSTR_CYC + 3);
    `CHK(sys_src, 7'h45)
    rdchk(osc_ctrl_pkg::SWITCH_IDX, 8'h50);
    rdy <= 8'h00;
    $display("t_switch done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    rst_b_in = 1'b0;
    bus_req = '0;
    rdy = '0;
    lock = 1'b0;
    preq = 8'h00;
    ext_cfg = 2'b01;
    tick = 1'b0;
    tune_val = 6'h00;
    fail = 3'b000;
    miscompares = 0;
    checked = 0;
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_reset;
    t_enable;
    t_freq;
    t_trim;
    t_mon;
    t_switch;
    summarize;
  end
endmodule
